/* frame_store.sv */
// Latched greyscale and dot-correction registers with a registered read port.
// Assumes write strobes are single-cycle pulses on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "led_consts.svh"

module frame_store
    import led_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic gs_we,
    input wire logic dc_we,
    input wire logic [`GS_BITS-1:0] frame,
    input wire logic [4:0] rd_index,
    output logic [`GS_WIDTH-1:0] rd_data,
    output logic [`GS_BITS-1:0] gs_flat,
    output logic [`DC_BITS-1:0] dc_flat
);
    store_s s;
    store_s next_s;

    // Channel n sits at bits n*width; index 0..15 greyscale, 16..31 dot correction
    always_comb begin
        next_s = s;
        if (gs_we) begin
            next_s.gs = frame;
        end
        if (dc_we) begin
            next_s.dc = frame[`DC_BITS-1:0];
        end
        if (rd_index[4]) begin
            next_s.rd_data = {6'h00, s.dc[32'(rd_index[3:0]) * `DC_WIDTH +: `DC_WIDTH]};
        end else begin
            next_s.rd_data = s.gs[32'(rd_index[3:0]) * `GS_WIDTH +: `GS_WIDTH];
        end
    end

    // Power-up values give full brightness and full current
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s.gs <= {`CHANNELS{`GS_RESET}};
            s.dc <= {`CHANNELS{`DC_RESET}};
            s.rd_data <= 12'h0000;
        end else begin
            s <= next_s;
        end
    end

    assign rd_data = s.rd_data;
    assign gs_flat = s.gs;
    assign dc_flat = s.dc;
endmodule // frame_store
`default_nettype wire

/* host_model.sv */
// Host side of the serial link: shifts frames out and pulses the load strobe.
// Assumes the bench calls its tasks; its timing is free-running, unrelated to clock.
`timescale 1ns/100ps
`default_nettype none

module host_model (
    output logic shift_clock,
    output logic serial_in,
    output logic load_strobe,
    input wire logic serial_out
);
    // Link idles with the clock and strobe low, so no fake edges at power-up
    initial begin
        shift_clock = 1'b0;
        serial_in = 1'b0;
        load_strobe = 1'b0;
    end

    // Sends the n low bits of d, top bit first; rx collects what leaves the far end
    task automatic frame(input logic [191:0] d, input int n, output logic [191:0] rx);
        rx = '0;
        #13;
        for (int i = n - 1; i >= 0; i--) begin
            rx[i] = serial_out;
            serial_in = d[i];
            #200 shift_clock = 1'b1;
            #200 shift_clock = 1'b0;
        end
        #200;
        // Released data line shows no stale bit, so nothing can lean on it
        serial_in = ~serial_in;
    endtask

    // Strobe held for eight system clocks, well over the sampler's need
    task automatic load();
        #200 load_strobe = 1'b1;
        #400 load_strobe = 1'b0;
        #200;
    endtask
endmodule // host_model
`default_nettype wire

/* led_consts.svh */
// Constants of the LED driver serial load and error logic.
// Assumes it is included by bare name wherever the numbers are needed.
`ifndef LED_CONSTS_SVH
`define LED_CONSTS_SVH

// Frame lengths and channel layout
`define CHANNELS 16
`define GS_WIDTH 12
`define DC_WIDTH 6
`define GS_BITS 192
`define DC_BITS 96

// Power-up values of the latched registers
`define GS_RESET 12'h0FFF
`define DC_RESET 6'h3F

// Status frame field positions
`define SF_OPEN_HI 176
`define SF_TERR 175
`define SF_DC_LO 72
`define SF_OPEN_LO 16

// Positions of the synchronised pins
`define P_SCLK 0
`define P_SIN 1
`define P_LOAD 2
`define P_MODE 3
`define P_OD 4
`define P_PWM 5

// Bus register byte offsets
`define OFS_STATUS 8'h00
`define OFS_MASK 8'h04
`define OFS_FLAGS 8'h08
`define OFS_COUNT 8'h0C
`define OFS_SEL 8'h10
`define OFS_DATA 8'h14

// Status and mask bits
`define ST_GS_LOADED 0
`define ST_DC_LOADED 1
`define ST_ERR_RAISED 2

`endif

/* led_driver_serial_load_and_error_flag_tb.sv */
// Self-checking bench of the LED driver serial core: bus, link, error line, PWM.
// Assumes host_model.sv, led_pkg.sv and led_consts.svh compile beforehand.
`timescale 1ns/100ps
`default_nettype none
`include "led_consts.svh"

module led_driver_serial_load_and_error_flag_tb;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic mode_sel = 1'b0;
    logic output_disable = 1'b1;
    logic pwm_count_clock = 1'b0;
    logic terr = 1'b0;
    logic twarn = 1'b0;
    logic [15:0] open_led = 16'h0000;
    logic hreadyout, hresp, irq, serial_out, error_n_out, error_n_oe;
    logic [31:0] hrdata;
    logic [15:0] channel_on;
    logic shift_clock, serial_in, load_strobe;
    logic [191:0] rx;
    logic [191:0] gs;
    logic [95:0] dc;
    logic [31:0] rd;
    int fail_count = 0;
    int n_tests = 0;
    // Open-drain line with its pull-up: low only while the pull-down is on
    wire logic err_line = error_n_oe ? error_n_out : 1'b1;

    // 20 MHz system clock
    always #25 clock = ~clock;

    led_serial_core i_led_serial_core (.clock(clock), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .irq(irq), .shift_clock(shift_clock), .serial_in(serial_in),
        .serial_out(serial_out), .load_strobe(load_strobe), .mode_sel(mode_sel),
        .output_disable(output_disable), .pwm_count_clock(pwm_count_clock),
        .thermal_error_threshold(terr), .thermal_warning_threshold(twarn),
        .open_led_threshold(open_led), .error_n_out(error_n_out),
        .error_n_oe(error_n_oe), .channel_on(channel_on));

    host_model i_host_model (.shift_clock(shift_clock), .serial_in(serial_in),
        .load_strobe(load_strobe), .serial_out(serial_out));

    task automatic chk(input logic [191:0] got, input logic [191:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("tests=%0d errors=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One single AHB-Lite transfer; waits on hready, never on a cycle count
    task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        r = hrdata;
        chk(hresp, 1'b0);
    endtask

    // Word readback lags the select write, so let the store settle first
    task automatic word_is(input logic [31:0] sel, input logic [11:0] exp);
        ahb(1'b1, `OFS_SEL, sel, rd);
        repeat (3) @(posedge clock);
        ahb(1'b0, `OFS_DATA, 32'h0000_0000, rd);
        chk(rd, exp);
    endtask

    task automatic t_reset();
        chk(err_line, 1'b1);
        ahb(1'b0, `OFS_STATUS, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
        ahb(1'b0, 32'h0000_0040, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
        ahb(1'b1, `OFS_FLAGS, 32'h0000_003F, rd);
        ahb(1'b0, `OFS_FLAGS, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0010);
    endtask

    // Short frame in correction mode; the register starts cleared
    task automatic t_dc();
        mode_sel <= 1'b1;
        repeat (6) @(posedge clock);
        for (int n = 0; n < 16; n++)
            dc[n*6 +: 6] = 6'h20 + n[5:0];
        i_host_model.frame({96'h0, dc}, 96, rx);
        chk(rx, 192'h0);
        chk(serial_out, dc[95]);
        i_host_model.load();
        word_is(32'h0000_0013, 12'h023);
    endtask

    // Long frame pushes the earlier bits out; then the status frame comes back
    task automatic t_gs();
        mode_sel <= 1'b0;
        open_led <= 16'hA5C3;
        terr <= 1'b1;
        repeat (8) @(posedge clock);
        for (int n = 0; n < 16; n++)
            gs[n*12 +: 12] = n[11:0];
        i_host_model.frame(gs, 192, rx);
        chk(rx, {96'h0, dc});
        i_host_model.load();
        word_is(32'h0000_0005, 12'h005);
        i_host_model.frame(192'h0, 192, rx);
        chk(rx, {16'hA5C3, 8'h80, dc, 40'h00_0000_0000, 16'hA5C3, 16'h0000});
        ahb(1'b0, `OFS_COUNT, 32'h0000_0000, rd);
        chk(rd, 32'h0000_00C0);
        open_led <= 16'h0000;
        terr <= 1'b0;
    endtask

    // Each entry is {disable, mode, thermal error, warning, open, line}
    task automatic t_err();
        logic [5:0] tbl [10];
        tbl = '{6'h01, 6'h02, 6'h08, 6'h05, 6'h12, 6'h23, 6'h28, 6'h39, 6'h34, 6'h33};
        for (int i = 0; i < 10; i++) begin
            @(posedge clock);
            {output_disable, mode_sel, terr, twarn} <= tbl[i][5:2];
            open_led <= tbl[i][1] ? 16'h0100 : 16'h0000;
            repeat (8) @(posedge clock);
            chk(err_line, tbl[i][0]);
        end
    endtask

    task automatic t_irq();
        ahb(1'b0, `OFS_STATUS, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0007);
        chk(irq, 1'b0);
        ahb(1'b1, `OFS_MASK, 32'h0000_0004, rd);
        ahb(1'b0, `OFS_MASK, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0004);
        repeat (3) @(posedge clock);
        chk(irq, 1'b1);
        ahb(1'b1, `OFS_STATUS, 32'h0000_0004, rd);
        repeat (3) @(posedge clock);
        chk(irq, 1'b0);
        ahb(1'b0, `OFS_STATUS, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0003);
    endtask

    task automatic pwm_pulse();
        @(posedge clock);
        pwm_count_clock <= 1'b1;
        repeat (4) @(posedge clock);
        pwm_count_clock <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    // Count 1 lights every channel with a nonzero level; disable blanks all
    task automatic t_pwm();
        open_led <= 16'h0000;
        pwm_pulse();
        chk(channel_on, 16'h0000);
        output_disable <= 1'b0;
        repeat (4) @(posedge clock);
        pwm_pulse();
        chk(channel_on, 16'hFFFE);
        output_disable <= 1'b1;
        repeat (6) @(posedge clock);
        chk(channel_on, 16'h0000);
    endtask

    // Main sequence: reset held eight cycles, then the scenarios in order
    initial begin
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        repeat (10) @(posedge clock);
        t_reset();
        t_dc();
        t_gs();
        t_err();
        t_irq();
        t_pwm();
        summarize();
    end

    // Whole run needs well under a millisecond; a hang ends here
    initial begin
        #2000000;
        fail_count++;
        summarize();
    end
endmodule // led_driver_serial_load_and_error_flag_tb
`default_nettype wire

/* led_pkg.sv */
// Types of the LED driver serial load and error logic.
// Assumes led_consts.svh sits in the same folder.
`default_nettype none
`include "led_consts.svh"

package led_pkg;

    // State of the top module
    typedef struct packed {
        logic [5:0] pin1;
        logic [5:0] pin2;
        logic [5:0] pin3;
        logic [17:0] fl1;
        logic [17:0] fl2;
        logic [`GS_BITS-1:0] sr;
        logic serial_out;
        logic [15:0] bit_count;
        logic [`GS_WIDTH-1:0] pwm_cnt;
        logic [`CHANNELS-1:0] channel_on;
        logic error_n_oe;
        logic error_n_out;
        logic [2:0] status;
        logic [2:0] mask;
        logic irq;
        logic [4:0] word_sel;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } core_s;

    // State of the latched frame store
    typedef struct packed {
        logic [`GS_BITS-1:0] gs;
        logic [`DC_BITS-1:0] dc;
        logic [`GS_WIDTH-1:0] rd_data;
    } store_s;

endpackage
`default_nettype wire

/* led_serial_core.sv */
// Serial load, status readback and error output of a 16-channel LED sink driver.
// Assumes an AHB-Lite master on clock; all pins come from outside that domain.
//
// What this block does
// - Each shift clock rise without a same-cycle load rise shifts serial_in in
// - Load strobe rise latches the shift register
// - serial_out carries bits leaving the register
// - Register length 96 or 192 by mode
// - serial_out can return status to host
// - No error: error pull-down stays off
// - Thermal or open-LED error pulls line low
// - Output disable masks the open-LED flag
// - Enabled greyscale mode: open or thermal error
// - Disabled greyscale mode: thermal error only
// - Disabled dot-correction mode: thermal warning only
// - Thermal error flag drives line, reads back
// - Separate thermal warning flag exists
// - Mode low greyscale 192, high dot-correction 96
// - Greyscale load refills register with status
// - Output disable turns channels off, clears counter
//
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "led_consts.svh"

module led_serial_core
    import led_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic irq,
    input wire logic shift_clock,
    input wire logic serial_in,
    output logic serial_out,
    input wire logic load_strobe,
    input wire logic mode_sel,
    input wire logic output_disable,
    input wire logic pwm_count_clock,
    input wire logic thermal_error_threshold,
    input wire logic thermal_warning_threshold,
    input wire logic [`CHANNELS-1:0] open_led_threshold,
    output logic error_n_out,
    output logic error_n_oe,
    output logic [`CHANNELS-1:0] channel_on
);
    core_s s;
    core_s next_s;
    logic [1:0] rst_pipe;
    logic rst_n;
    logic sclk_rise;
    logic load_rise;
    logic pwm_rise;
    logic mode;
    logic od;
    logic terr;
    logic twarn;
    logic open_any;
    logic pull_low;
    logic gs_we;
    logic dc_we;
    logic take;
    logic [2:0] events;
    logic [`GS_BITS-1:0] status_frame;
    logic [`GS_BITS-1:0] gs_flat;
    logic [`DC_BITS-1:0] dc_flat;
    logic [`GS_WIDTH-1:0] word_data;
    logic [`CHANNELS-1:0] on_vec;

    // Reset enters asynchronously but is released on the clock
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // Edges are found on the second sync stage only, never the first
    assign sclk_rise = s.pin2[`P_SCLK] & ~s.pin3[`P_SCLK];
    assign load_rise = s.pin2[`P_LOAD] & ~s.pin3[`P_LOAD];
    assign pwm_rise = s.pin2[`P_PWM] & ~s.pin3[`P_PWM];
    assign mode = s.pin2[`P_MODE];
    assign od = s.pin2[`P_OD];
    assign terr = s.fl2[16];
    assign twarn = s.fl2[17];
    assign open_any = |s.fl2[15:0];
    assign gs_we = load_rise & ~mode;
    assign dc_we = load_rise & mode;
    assign take = hsel & htrans[1] & hready;

    // Error pull-down selection; enabled with mode high is undefined, treated as greyscale mode
    always_comb begin
        if (od && mode) begin
            pull_low = twarn;
        end else if (od) begin
            pull_low = terr;
        end else begin
            pull_low = open_any | terr;
        end
    end

    // Status frame: open flags twice, thermal error, dot correction, no short flags
    always_comb begin
        status_frame = '0;
        status_frame[`SF_OPEN_HI +: `CHANNELS] = s.fl2[15:0];
        status_frame[`SF_OPEN_LO +: `CHANNELS] = s.fl2[15:0];
        status_frame[`SF_TERR] = terr;
        status_frame[`SF_DC_LO +: `DC_BITS] = dc_flat;
    end

    // Per-channel PWM compare; a channel is lit from count 1 up to its value
    genvar ch;
    generate
        for (ch = 0; ch < `CHANNELS; ch++) begin : g_pwm
            assign on_vec[ch] = (s.pwm_cnt != 12'h0000) &&
                (s.pwm_cnt <= gs_flat[ch * `GS_WIDTH +: `GS_WIDTH]);
        end
    endgenerate

    assign events = {pull_low & ~s.error_n_oe, dc_we, gs_we};

    // Next state of the whole block
    always_comb begin
        next_s = s;
        next_s.pin1 = {pwm_count_clock, output_disable, mode_sel, load_strobe,
            serial_in, shift_clock};
        next_s.pin2 = s.pin1;
        next_s.pin3 = s.pin2;
        next_s.fl1 = {thermal_warning_threshold, thermal_error_threshold,
            open_led_threshold};
        next_s.fl2 = s.fl1;
        // Load wins over a shift that lands in the same cycle
        if (load_rise) begin
            next_s.bit_count = 16'h0000;
            if (!mode) begin
                next_s.sr = status_frame;
            end
        end else if (sclk_rise) begin
            next_s.sr = {s.sr[`GS_BITS-2:0], s.pin2[`P_SIN]};
            next_s.bit_count = s.bit_count + 16'h0001;
        end
        // Tap sits at the end of the active length, so cascades see whole frames
        next_s.serial_out = mode ? next_s.sr[`DC_BITS-1] : next_s.sr[`GS_BITS-1];
        // Counter saturates so a long frame never wraps channels back on
        if (od) begin
            next_s.pwm_cnt = 12'h0000;
        end else if (pwm_rise && s.pwm_cnt != 12'h0FFF) begin
            next_s.pwm_cnt = s.pwm_cnt + 12'h001;
        end
        next_s.channel_on = od ? 16'h0000 : on_vec;
        next_s.error_n_oe = pull_low;
        next_s.error_n_out = 1'b0;
        // Bus write in its data phase; clear first so a same-cycle event survives
        if (s.wr_pend) begin
            unique case (s.wr_addr)
                `OFS_STATUS: next_s.status = s.status & ~hwdata[2:0];
                `OFS_MASK: next_s.mask = hwdata[2:0];
                `OFS_SEL: next_s.word_sel = hwdata[4:0];
                default: next_s.wr_pend = 1'b0;
            endcase
        end
        next_s.status = next_s.status | events;
        next_s.wr_pend = take & hwrite;
        next_s.wr_addr = haddr[7:0];
        // Read data are prepared in the address phase from post-write values
        next_s.hrdata = 32'h0000_0000;
        if (take && !hwrite) begin
            unique case (haddr[7:0])
                `OFS_STATUS: next_s.hrdata = {29'h0000_0000, next_s.status};
                `OFS_MASK: next_s.hrdata = {29'h0000_0000, next_s.mask};
                `OFS_FLAGS: next_s.hrdata = {26'h000_0000, pull_low, od, mode,
                    twarn, terr, open_any};
                `OFS_COUNT: next_s.hrdata = {16'h0000, s.bit_count};
                `OFS_SEL: next_s.hrdata = {27'h000_0000, next_s.word_sel};
                `OFS_DATA: next_s.hrdata = {20'h0_0000, word_data};
                default: next_s.hrdata = 32'h0000_0000;
            endcase
        end
        next_s.irq = |(next_s.status & next_s.mask);
        next_s.hreadyout = 1'b1;
        next_s.hresp = 1'b0;
    end

    // The single state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.hreadyout <= 1'b1;
            s.mask <= 3'h0;
        end else begin
            s <= next_s;
        end
    end

    // Latched frames live in their own store
    frame_store u_store (
        .clock(clock),
        .rst_n(rst_n),
        .gs_we(gs_we),
        .dc_we(dc_we),
        .frame(s.sr),
        .rd_index(s.word_sel),
        .rd_data(word_data),
        .gs_flat(gs_flat),
        .dc_flat(dc_flat)
    );

    assign hreadyout = s.hreadyout;
    assign hrdata = s.hrdata;
    assign hresp = s.hresp;
    assign irq = s.irq;
    assign serial_out = s.serial_out;
    assign error_n_out = s.error_n_out;
    assign error_n_oe = s.error_n_oe;
    assign channel_on = s.channel_on;

    // Checks on the block's own behaviour
    property p_shift_in;
        @(posedge clock) disable iff (!rst_n)
        (sclk_rise && !load_rise) |=> (s.sr[0] == $past(s.pin2[`P_SIN]))
            && (s.sr[`GS_BITS-1:1] == $past(s.sr[`GS_BITS-2:0]));
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("shift missed");

    property p_gs_status;
        @(posedge clock) disable iff (!rst_n)
        gs_we |=> (s.sr == $past(status_frame)) && (u_store.gs_flat == $past(s.sr));
    endproperty
    a_gs_status: assert property (p_gs_status) else $error("gs load wrong");

    property p_dc_keep;
        @(posedge clock) disable iff (!rst_n)
        dc_we |=> (s.sr == $past(s.sr)) && (dc_flat == $past(s.sr[`DC_BITS-1:0]));
    endproperty
    a_dc_keep: assert property (p_dc_keep) else $error("dc load wrong");

    property p_tap;
        @(posedge clock) disable iff (!rst_n)
        ##1 serial_out == ($past(mode) ? s.sr[`DC_BITS-1] : s.sr[`GS_BITS-1]);
    endproperty
    a_tap: assert property (p_tap) else $error("serial_out tap wrong");

    property p_release;
        @(posedge clock) disable iff (!rst_n)
        (s.fl2 == 18'h0_0000) |=> !error_n_oe;
    endproperty
    a_release: assert property (p_release) else $error("error held low");

    property p_enabled_err;
        @(posedge clock) disable iff (!rst_n)
        (!od && (open_any || terr)) |=> error_n_oe && !error_n_out;
    endproperty
    a_enabled_err: assert property (p_enabled_err) else $error("error not driven");

    property p_mask_open;
        @(posedge clock) disable iff (!rst_n)
        (od && !mode) |=> error_n_oe == $past(terr);
    endproperty
    a_mask_open: assert property (p_mask_open) else $error("open flag not masked");

    property p_warn;
        @(posedge clock) disable iff (!rst_n)
        (od && mode) |=> error_n_oe == $past(twarn);
    endproperty
    a_warn: assert property (p_warn) else $error("warning select wrong");

    property p_terr_read;
        @(posedge clock) disable iff (!rst_n)
        gs_we |=> s.sr[`SF_TERR] == $past(terr);
    endproperty
    a_terr_read: assert property (p_terr_read) else $error("thermal bit lost");

    property p_off;
        @(posedge clock) disable iff (!rst_n)
        od [*2] |=> (channel_on == 16'h0000) && (s.pwm_cnt == 12'h000);
    endproperty
    a_off: assert property (p_off) else $error("outputs not off");

    // Further checks on shifting, sticky status and the error line
    property p_sr_hold;
        @(posedge clock) disable iff (!rst_n)
        (!sclk_rise && !load_rise) |=> (s.sr == $past(s.sr));
    endproperty
    a_sr_hold: assert property (p_sr_hold) else $error("shift register moved");

    property p_count_step;
        @(posedge clock) disable iff (!rst_n)
        (sclk_rise && !load_rise) |=> (s.bit_count == $past(s.bit_count) + 16'h0001);
    endproperty
    a_count_step: assert property (p_count_step) else $error("shift count wrong");

    property p_gs_flag;
        @(posedge clock) disable iff (!rst_n)
        gs_we |=> s.status[`ST_GS_LOADED];
    endproperty
    a_gs_flag: assert property (p_gs_flag) else $error("gs load not flagged");

    property p_dc_flag;
        @(posedge clock) disable iff (!rst_n)
        dc_we |=> s.status[`ST_DC_LOADED];
    endproperty
    a_dc_flag: assert property (p_dc_flag) else $error("dc load not flagged");

    property p_err_event;
        @(posedge clock) disable iff (!rst_n)
        (pull_low && !error_n_oe) |=> s.status[`ST_ERR_RAISED];
    endproperty
    a_err_event: assert property (p_err_event) else $error("error event lost");

    property p_status_out;
        @(posedge clock) disable iff (!rst_n)
        gs_we |=> (serial_out == $past(status_frame[`GS_BITS-1]));
    endproperty
    a_status_out: assert property (p_status_out) else $error("status not at output");

    property p_open_masked;
        @(posedge clock) disable iff (!rst_n)
        (od && !terr && !twarn) |=> !error_n_oe;
    endproperty
    a_open_masked: assert property (p_open_masked) else $error("masked line pulled");

    property p_terr_low;
        @(posedge clock) disable iff (!rst_n)
        (terr && !(od && mode)) |=> error_n_oe;
    endproperty
    a_terr_low: assert property (p_terr_low) else $error("thermal error not shown");

    property p_warn_ignored;
        @(posedge clock) disable iff (!rst_n)
        (!od && twarn && !terr && !open_any) |=> !error_n_oe;
    endproperty
    a_warn_ignored: assert property (p_warn_ignored) else $error("warning pulled line");

    c_gs_load: cover property (@(posedge clock) disable iff (!rst_n) gs_we);
    c_dc_load: cover property (@(posedge clock) disable iff (!rst_n) dc_we);
    c_err_low: cover property (@(posedge clock) disable iff (!rst_n) $rose(error_n_oe));
    c_irq: cover property (@(posedge clock) disable iff (!rst_n) $rose(irq));
    c_warn_low: cover property (@(posedge clock) disable iff (!rst_n) od && mode && twarn);
endmodule // led_serial_core
`default_nettype wire
